// ---- verilog/stepper_decay_chopper_protect.sv ----
module stepper_decay_chopper_protect
	import sdc_pkg::*;
#(
	parameter int P_CHOP_CYC   = sdc_pkg::CHOP_CYC,
	parameter int P_DEAD_CYC   = sdc_pkg::DEAD_CYC,
	parameter int P_TSD_DB_CYC = sdc_pkg::TSD_DB_CYC,
	parameter int P_ISD_DB_CYC = sdc_pkg::ISD_DB_CYC
)
(
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	// decay select pin, level and open detection
	input  wire logic       i_decay_high,
	input  wire logic       i_decay_open,
	// per channel control, index 0 is channel a
	input  wire logic [1:0] i_dir_neg,
	input  wire logic [1:0] i_target_rising,
	input  wire logic [1:0] i_limit_reached,
	// protection detectors and sleep
	input  wire logic       i_over_temp,
	input  wire logic [1:0] i_short,
	input  wire logic       i_sleep,
	// bridge switches
	output logic [1:0]      o_high_side_switch_first,
	output logic [1:0]      o_high_side_switch_second,
	output logic [1:0]      o_low_side_switch_first,
	output logic [1:0]      o_low_side_switch_second,
	// status
	output logic            o_over_temperature_shutdown,
	output logic            o_over_current_shutdown
);

	localparam int PW = $clog2(P_CHOP_CYC);
	localparam int TW = $clog2(P_TSD_DB_CYC + 1);
	localparam int IW = $clog2(P_ISD_DB_CYC + 1);

	generate
		if (P_CHOP_CYC < 4 || P_TSD_DB_CYC < 1 || P_ISD_DB_CYC < 1)
		begin : g_chk
			$error("chop period or dead band too short");
		end
	endgenerate

	// ---------------------------------------------------------------
	// chopping period divider
	// ---------------------------------------------------------------
	logic [PW-1:0] chop_cnt;
	wire           chop_last  = (chop_cnt == PW'(P_CHOP_CYC - 1));
	wire           chop_start = (chop_cnt == '0);
	wire           mix_fast   = (chop_cnt < PW'((P_CHOP_CYC * MIX_FAST_PCT) / 100));

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			chop_cnt <= '0;
		else
			chop_cnt <= chop_last ? '0 : chop_cnt + PW'(1);
	end

	// ---------------------------------------------------------------
	// thermal shutdown, auto return
	// ---------------------------------------------------------------
	logic [TW-1:0] tsd_cnt;
	logic          tsd_active;
	wire           tsd_done = (tsd_cnt == TW'(P_TSD_DB_CYC - 1));

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			tsd_cnt    <= '0;
			tsd_active <= 1'b0;
		end
		else
		begin
			if (!i_over_temp)
				tsd_cnt <= '0;
			else if (!tsd_done)
				tsd_cnt <= tsd_cnt + TW'(1);
			tsd_active <= i_over_temp & (tsd_active | tsd_done);
		end
	end

	// ---------------------------------------------------------------
	// overcurrent shutdown, latched
	// ---------------------------------------------------------------
	logic [IW-1:0] isd_cnt [2];
	logic [1:0]    isd_hit;
	logic          isd_latched;

	genvar c;
	generate
		for (c = 0; c < 2; c++)
		begin : g_isd
			assign isd_hit[c] = (isd_cnt[c] == IW'(P_ISD_DB_CYC - 1)) & i_short[c];
			always_ff @(posedge i_ref_clk)
			begin
				if (i_rst)
					isd_cnt[c] <= '0;
				else if (!i_short[c])
					isd_cnt[c] <= '0;
				else if (!isd_hit[c])
					isd_cnt[c] <= isd_cnt[c] + IW'(1);
			end
		end
	endgenerate

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			isd_latched <= 1'b0;
		else if (|isd_hit)
			isd_latched <= 1'b1;
		else if (i_sleep)
			isd_latched <= 1'b0;
	end

	wire outputs_off = tsd_active | isd_latched | i_sleep;

	// ---------------------------------------------------------------
	// per channel chopper and bridge
	// ---------------------------------------------------------------
	sdc_bridge_if bridge [2] ();

	generate
		for (c = 0; c < 2; c++)
		begin : g_ch
			logic      in_charge;
			sdc_mode_t decay_mode;
			sdc_mode_t next_mode;

			assign decay_mode = i_decay_open ? ((i_target_rising[c] | !mix_fast) ? SDC_SLOW : SDC_FAST)
			                  : (i_decay_high ? SDC_FAST : SDC_SLOW);
			assign next_mode  = outputs_off ? SDC_OFF : (in_charge ? SDC_CHARGE : decay_mode);

			always_ff @(posedge i_ref_clk)
			begin
				if (i_rst)
					in_charge <= 1'b0;
				else if (chop_last)
					in_charge <= 1'b1;
				else if (i_limit_reached[c])
					in_charge <= 1'b0;
			end

			assign bridge[c].mode    = next_mode;
			assign bridge[c].dir_neg = i_dir_neg[c];

			sdc_bridge_switch #(
				.P_DEAD_CYC (P_DEAD_CYC)
			) u_sw (
				.i_ref_clk (i_ref_clk),
				.i_rst     (i_rst),
				.bridge    (bridge[c])
			);

			assign o_high_side_switch_first[c]  = bridge[c].sw[SW_HS_FIRST];
			assign o_high_side_switch_second[c] = bridge[c].sw[SW_HS_SECOND];
			assign o_low_side_switch_first[c]   = bridge[c].sw[SW_LS_FIRST];
			assign o_low_side_switch_second[c]  = bridge[c].sw[SW_LS_SECOND];
		end
	endgenerate

	assign o_over_temperature_shutdown = tsd_active;
	assign o_over_current_shutdown     = isd_latched;

	wire unused_start = chop_start;

endmodule

// ---- verilog/sdc_pkg.sv ----
package sdc_pkg;

	// ---------------------------------------------------------------
	// clock and chopping timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ        = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int CHOP_HZ       = 30_000;
	localparam int CHOP_CYC      = CLK_HZ / CHOP_HZ;
	localparam int MIX_FAST_PCT  = 75;
	localparam int MIX_FAST_CYC  = (CHOP_CYC * MIX_FAST_PCT) / 100;

	// ---------------------------------------------------------------
	// dead time and detector dead bands (least times, rounded up)
	// ---------------------------------------------------------------
	localparam int DEAD_NS       = 500;
	localparam int DEAD_CYC      = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TSD_DB_NS     = 2000;
	localparam int TSD_DB_CYC    = (TSD_DB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ISD_DB_NS     = 1000;
	localparam int ISD_DB_CYC    = (ISD_DB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// reference divider of the external current comparator
	localparam int VREF_GAIN     = 5;

	// ---------------------------------------------------------------
	// switch bit positions and bridge patterns
	// ---------------------------------------------------------------
	localparam int SW_HS_FIRST   = 0;
	localparam int SW_HS_SECOND  = 1;
	localparam int SW_LS_FIRST   = 2;
	localparam int SW_LS_SECOND  = 3;
	localparam logic [3:0] PAT_OFF        = 4'h0;
	localparam logic [3:0] PAT_POS_CHARGE = 4'h9;
	localparam logic [3:0] PAT_POS_FAST   = 4'h6;
	localparam logic [3:0] PAT_NEG_CHARGE = 4'h6;
	localparam logic [3:0] PAT_NEG_FAST   = 4'h9;
	localparam logic [3:0] PAT_SLOW       = 4'hC;

	typedef enum logic [1:0] {
		SDC_OFF,
		SDC_CHARGE,
		SDC_FAST,
		SDC_SLOW
	} sdc_mode_t;

endpackage

// ---- verilog/sdc_bridge_if.sv ----
interface sdc_bridge_if;
	import sdc_pkg::*;

	sdc_mode_t  mode;
	logic       dir_neg;
	logic [3:0] sw;

	modport ctl (output mode, output dir_neg, input sw);
	modport drv (input mode, input dir_neg, output sw);
endinterface

// ---- verilog/sdc_bridge_switch.sv ----
module sdc_bridge_switch
	import sdc_pkg::*;
#(
	parameter int P_DEAD_CYC = sdc_pkg::DEAD_CYC
)
(
	// clock and reset
	input  wire logic   i_ref_clk,
	input  wire logic   i_rst,
	// bridge request and switch drive
	sdc_bridge_if.drv   bridge
);

	localparam int CW = $clog2(P_DEAD_CYC + 1);

	generate
		if (P_DEAD_CYC < 1)
		begin : g_chk
			$error("dead time must be at least one cycle");
		end
	endgenerate

	logic [3:0]    applied;
	logic [3:0]    pending;
	logic [CW-1:0] dead_cnt;
	logic [3:0]    sw_q;

	// ---------------------------------------------------------------
	// pattern selection
	// ---------------------------------------------------------------
	wire [3:0] pat_charge = bridge.dir_neg ? PAT_NEG_CHARGE : PAT_POS_CHARGE;
	wire [3:0] pat_fast   = bridge.dir_neg ? PAT_NEG_FAST : PAT_POS_FAST;
	wire [3:0] target     = (bridge.mode == SDC_CHARGE) ? pat_charge :
	                        (bridge.mode == SDC_FAST)   ? pat_fast :
	                        (bridge.mode == SDC_SLOW)   ? PAT_SLOW : PAT_OFF;
	wire       dead_done  = (dead_cnt == CW'(P_DEAD_CYC - 1));
	// switches turning off drop at once, ones turning on wait
	wire [3:0] next_sw    = applied & pending;

	// ---------------------------------------------------------------
	// dead time sequencing
	// ---------------------------------------------------------------
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			applied  <= PAT_OFF;
			pending  <= PAT_OFF;
			dead_cnt <= '0;
			sw_q     <= PAT_OFF;
		end
		else
		begin
			sw_q <= next_sw;
			if (target != pending)
			begin
				pending  <= target;
				applied  <= applied & target;
				dead_cnt <= '0;
			end
			else if (pending != applied)
			begin
				if (dead_done)
					applied <= pending;
				else
					dead_cnt <= dead_cnt + CW'(1);
			end
		end
	end

	assign bridge.sw = sw_q;

endmodule

// ---- bench/sdc_props.sv ----
module sdc_props
	import sdc_pkg::*;
#(
	parameter int P_TSD_DB_CYC = 20,
	parameter int P_ISD_DB_CYC = 10
)
(
	// watched ports
	input wire logic       i_ref_clk,
	input wire logic       i_rst,
	input wire logic       i_over_temp,
	input wire logic [1:0] i_short,
	input wire logic       i_sleep,
	input wire logic [1:0] o_high_side_switch_first,
	input wire logic [1:0] o_high_side_switch_second,
	input wire logic [1:0] o_low_side_switch_first,
	input wire logic [1:0] o_low_side_switch_second,
	input wire logic       o_over_temperature_shutdown,
	input wire logic       o_over_current_shutdown
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0]  sw_a;
	logic [1:0]  shoot;
	logic        sw_any;
	logic        shut;
	logic [15:0] n_hot;
	logic [15:0] n_short;
	assign sw_a = {o_low_side_switch_second[0], o_low_side_switch_first[0],
		o_high_side_switch_second[0], o_high_side_switch_first[0]};
	assign shoot = (o_high_side_switch_first & o_low_side_switch_first)
		| (o_high_side_switch_second & o_low_side_switch_second);
	assign sw_any = |{o_high_side_switch_first, o_high_side_switch_second,
		o_low_side_switch_first, o_low_side_switch_second};
	assign shut = o_over_temperature_shutdown | o_over_current_shutdown;
	// consecutive detector cycles
	always_ff @(posedge i_ref_clk)
	begin
		n_hot   <= i_over_temp ? n_hot + 16'h0001 : 16'h0000;
		n_short <= (|i_short) ? n_short + 16'h0001 : 16'h0000;
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence s_turn_off;
		|($past(sw_a) & ~sw_a);
	endsequence
	sequence s_none_on;
		(sw_a & ~$past(sw_a)) == 4'h0;
	endsequence
	sequence s_shut_held;
		shut [*3];
	endsequence
	a_no_shoot: assert property (shoot == 2'h0)
		else $error("leg conducts high and low");
	a_dead_gap: assert property (s_turn_off |=> s_none_on [*4])
		else $error("switch on inside dead time");
	a_off_shut: assert property (s_shut_held |-> !sw_any)
		else $error("switch on during shutdown");
	a_ocp_hold: assert property (o_over_current_shutdown && !i_sleep |=> o_over_current_shutdown)
		else $error("overcurrent latch dropped");
	a_ocp_clear: assert property (i_sleep && i_short == 2'h0 |=> !o_over_current_shutdown)
		else $error("sleep left overcurrent latch set");
	a_ocp_mask: assert property ($rose(o_over_current_shutdown) |-> n_short >= P_ISD_DB_CYC)
		else $error("overcurrent set before dead band");
	a_tsd_mask: assert property ($rose(o_over_temperature_shutdown) |-> n_hot >= P_TSD_DB_CYC)
		else $error("thermal set before dead band");
	a_tsd_free: assert property (o_over_temperature_shutdown && !i_over_temp |=> !o_over_temperature_shutdown)
		else $error("thermal shutdown not released");
endmodule
bind stepper_decay_chopper_protect sdc_props #(.P_TSD_DB_CYC(P_TSD_DB_CYC), .P_ISD_DB_CYC(P_ISD_DB_CYC)) u_props (.*);

// ---- bench/sdc_motor_model.sv ----
module sdc_motor_model
	import sdc_pkg::*;
#(
	parameter int P_LAT = 2
)
(
	// bridge seen from the winding
	input  wire logic       i_ref_clk,
	input  wire logic [1:0] i_dir_neg,
	input  wire logic [1:0] i_hs_first,
	input  wire logic [1:0] i_hs_second,
	input  wire logic [1:0] i_ls_first,
	input  wire logic [1:0] i_ls_second,
	// sense comparator
	output logic [1:0]      o_limit_reached
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] n_charge [2] = '{8'h00, 8'h00};
	for (genvar c = 0; c < 2; c++)
	begin : g_ch
		logic [3:0] pat;
		assign pat = {i_ls_second[c], i_ls_first[c], i_hs_second[c], i_hs_first[c]};
		// current climbs only while the charge pattern is on
		always @(posedge i_ref_clk)
			n_charge[c] <= (pat == (i_dir_neg[c] ? PAT_NEG_CHARGE : PAT_POS_CHARGE)) ? n_charge[c] + 8'h01 : 8'h00;
		assign o_limit_reached[c] = n_charge[c] >= P_LAT;
	end
endmodule

// ---- bench/stepper_decay_chopper_protect_tb.sv ----
module stepper_decay_chopper_protect_tb
	import sdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic        hi;
		logic        open;
		logic [1:0]  dir;
		logic [1:0]  rise;
		logic [15:0] ea;
		logic [15:0] eb;
	} sdc_row_t;
	localparam sdc_row_t ROWS [4] = '{
		'{1'h0, 1'h0, 2'h2, 2'h0, 16'h1200, 16'h1040},
		'{1'h1, 1'h0, 2'h2, 2'h0, 16'h0240, 16'h0240},
		'{1'h0, 1'h1, 2'h2, 2'h0, 16'h1240, 16'h1240},
		'{1'h1, 1'h1, 2'h1, 2'h1, 16'h1040, 16'h1240}};
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        hi = 1'h0;
	logic        open = 1'h0;
	logic        ot = 1'h0;
	logic        sleep = 1'h0;
	logic        clr = 1'h0;
	logic [1:0]  dir = 2'h0;
	logic [1:0]  rise = 2'h0;
	logic [1:0]  shrt = 2'h0;
	logic [1:0]  lim, hs1, hs2, ls1, ls2;
	logic        ots, ocs;
	logic [3:0]  pat_a, pat_b;
	logic [15:0] seen_a, seen_b;
	int          fails = 0;
	int          n_checks = 0;
	int          cyc = 0;
	assign pat_a = {ls2[0], ls1[0], hs2[0], hs1[0]};
	assign pat_b = {ls2[1], ls1[1], hs2[1], hs1[1]};
	always #50 clk = ~clk;
	stepper_decay_chopper_protect #(.P_CHOP_CYC(60)) u_dut (.i_ref_clk(clk), .i_rst(rst),
		.i_decay_high(hi), .i_decay_open(open), .i_dir_neg(dir), .i_target_rising(rise),
		.i_limit_reached(lim), .i_over_temp(ot), .i_short(shrt), .i_sleep(sleep),
		.o_high_side_switch_first(hs1), .o_high_side_switch_second(hs2), .o_low_side_switch_first(ls1),
		.o_low_side_switch_second(ls2), .o_over_temperature_shutdown(ots), .o_over_current_shutdown(ocs));
	sdc_motor_model u_motor (.i_ref_clk(clk), .i_dir_neg(dir), .i_hs_first(hs1), .i_hs_second(hs2),
		.i_ls_first(ls1), .i_ls_second(ls2), .o_limit_reached(lim));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic close_out();
		if (fails == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// full bridge patterns seen, and the hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		seen_a <= clr ? 16'h0000 : seen_a | ((pat_a inside {4'h9, 4'h6, 4'hC}) << pat_a);
		seen_b <= clr ? 16'h0000 : seen_b | ((pat_b inside {4'h9, 4'h6, 4'hC}) << pat_b);
		if (cyc == 5000)
		begin
			fails++;
			close_out();
		end
	end
	initial
	begin
		step(10);
		chk("reset state", 16'h0000, {6'h00, ots, ocs, hs1, hs2, ls1, ls2});
		rst <= 1'h0;
		foreach (ROWS[i])
		begin
			hi <= ROWS[i].hi;
			open <= ROWS[i].open;
			dir <= ROWS[i].dir;
			rise <= ROWS[i].rise;
			step(130);
			clr <= 1'h1;
			step(1);
			clr <= 1'h0;
			step(125);
			chk("patterns a", ROWS[i].ea, seen_a);
			chk("patterns b", ROWS[i].eb, seen_b);
		end
		ot <= 1'h1;
		step(19);
		ot <= 1'h0;
		step(3);
		chk("heat glitch", 16'h0000, {15'h0000, ots});
		ot <= 1'h1;
		step(30);
		chk("heat off", 16'h0100, {7'h00, ots, hs1, hs2, ls1, ls2});
		ot <= 1'h0;
		step(3);
		chk("heat release", 16'h0000, {15'h0000, ots});
		step(100);
		chk("resume", 16'h0001, {15'h0000, |{hs1, hs2, ls1, ls2}});
		shrt <= 2'h2;
		step(9);
		shrt <= 2'h0;
		step(3);
		chk("short glitch", 16'h0000, {15'h0000, ocs});
		shrt <= 2'h2;
		step(15);
		shrt <= 2'h0;
		step(40);
		chk("short latch", 16'h0100, {7'h00, ocs, hs1, hs2, ls1, ls2});
		sleep <= 1'h1;
		step(2);
		sleep <= 1'h0;
		step(3);
		chk("sleep clear", 16'h0000, {15'h0000, ocs});
		shrt <= 2'h1;
		step(15);
		shrt <= 2'h0;
		step(3);
		chk("short again", 16'h0001, {15'h0000, ocs});
		rst <= 1'h1;
		step(2);
		rst <= 1'h0;
		step(1);
		chk("reset clear", 16'h0000, {7'h00, ocs, hs1, hs2, ls1, ls2});
		close_out();
	end
endmodule
